/* File: rtl/uabd_pkg.sv */
/*
  shared constants of the auto-baud measurement unit: register offsets,
  bit positions, reset values, state codes and prescaler limits.
  assumes a 32-bit apb bus with byte addresses and one word per register.
*/
package uabd_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BAUD_CONTROL = 8'h00;  // baud_control_reg
  localparam logic [7:0] OFS_DIVISOR_LOW  = 8'h04;  // baud_divisor_low
  localparam logic [7:0] OFS_DIVISOR_HIGH = 8'h08;  // baud_divisor_high
  localparam logic [7:0] OFS_RECEIVE_DATA = 8'h0C;  // receive_data_reg, read clears flag
  localparam logic [7:0] OFS_STATUS       = 8'h10;  // flag and measurement state

  // ---------------------------------------------------------------
  // bit positions in baud_control_reg
  // ---------------------------------------------------------------
  localparam int BIT_ENABLE    = 0;  // autobaud_enable_bit
  localparam int BIT_WAKE      = 1;  // wake_on_break_enable
  localparam int BIT_OVERFLOW  = 2;  // autobaud_overflow_flag
  localparam int BIT_WIDE      = 3;  // wide_divisor_select
  localparam int BIT_HIGH_SPD  = 4;  // high_speed_select
  localparam int BIT_MEASURING = 5;  // read only: sequence running

  // bit positions in the status register
  localparam int BIT_RX_FLAG   = 0;  // receive_int_flag
  localparam int BIT_RX_IDLE   = 1;  // normal receiver held idle

  // ---------------------------------------------------------------
  // divisor reset value, counter start and counter maximum
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_DIVISOR = 16'h0000;
  localparam logic [15:0] CNT_START   = 16'h0001;  // counter starts at one
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;

  // ---------------------------------------------------------------
  // measurement clock: system clock divided by 512, 128 or 32
  // ---------------------------------------------------------------
  localparam logic [8:0] PRE_LAST_SLOW = 9'h1FF;  // divide by 512
  localparam logic [8:0] PRE_LAST_MID  = 9'h07F;  // divide by 128
  localparam logic [8:0] PRE_LAST_FAST = 9'h01F;  // divide by 32

  // number of rising edges of the sync character
  localparam logic [2:0] EDGE_LAST = 3'h5;

  // ---------------------------------------------------------------
  // measurement sequence states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,  // no measurement
    ST_BREAK_FALL = 3'b001,  // wait for break to begin
    ST_BREAK_RISE = 3'b010,  // wait for break to end
    ST_START_FALL = 3'b011,  // wait for sync start bit
    ST_FIRST_RISE = 3'b100,  // wait for first rising edge
    ST_COUNT      = 3'b101   // counting bit periods
  } uabd_state_type;

endpackage

/* File: rtl/uabd_top.sv */
/*
  auto-baud measurement unit of an asynchronous serial receiver: an apb
  register slave, a receive line synchroniser, a measurement prescaler and
  the sequence that times a 0x55 sync character into a 16-bit divisor.
  assumes one clock pclk at 20 MHz, apb master signals synchronous to it,
  rx_line asynchronous, and a normal receiver outside that obeys rx_hold_idle.
*/
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps

// Operation
// - enable bit set starts the measurement
// - normal receiver held idle while measuring
// - counting begins at first rising edge
// - fifth rising edge stops, divisor keeps value
// - completion clears enable, sets receive flag
// - data register read clears receive flag
// - both divisor bytes form one counter
// - counter advances at eighth of base rate
// - rate bits pick divide 512/128/32
// - counter starts at one, software subtracts
// - with wake enabled, skip break first
// - overflow sets flag, counting continues
// - overflow clear needs enable cleared first
module uabd_top
  import uabd_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line and normal receiver
  input  wire logic        rx_line,
  input  wire logic [7:0]  rx_data,
  output logic             rx_hold_idle,
  output logic             receive_int_flag,
  // divisor setting for the baud rate generator
  output logic [15:0]      baud_divisor,
  output logic             wide_divisor_select,
  output logic             high_speed_select
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  uabd_state_type state_reg;          // sequence state
  uabd_state_type state_next;         // its next value
  logic        enable_reg;            // autobaud_enable_bit
  logic        wake_reg;              // wake_on_break_enable
  logic        overflow_reg;          // autobaud_overflow_flag
  logic        wide_reg;              // wide_divisor_select
  logic        high_reg;              // high_speed_select
  logic        rx_flag_reg;           // receive_int_flag
  logic [15:0] divisor_reg;           // baud_divisor_high:low pair
  logic [8:0]  pre_reg;               // measurement prescaler
  logic [2:0]  edge_reg;              // rising edges seen while counting
  logic [31:0] prdata_reg;            // read data captured in setup
  logic        rx_meta_reg;           // synchroniser first stage
  logic        rx_sync_reg;           // synchroniser second stage
  logic        rx_last_reg;           // previous synchronised level
  logic        rx_rise;               // rising edge of the line
  logic        rx_fall;               // falling edge of the line
  logic [8:0]  pre_last;              // selected prescaler limit
  logic        tick;                  // one measurement clock
  logic        measuring;             // any non-idle state
  logic        done;                  // fifth edge seen
  logic        break_end;             // end of break on wake path
  logic        first_edge;            // counting begins
  logic        wr_access;             // apb write access phase
  logic        rd_access;             // apb read access phase
  logic        setup;                 // apb setup phase
  logic        addr_ok;               // address is mapped
  logic        wr_ctrl;               // write to control register
  logic        wr_low;                // write to divisor low byte
  logic        wr_high;               // write to divisor high byte
  logic        count_step;            // counter advances this cycle
  logic        count_wrap;            // counter passes its maximum

  // ---------------------------------------------------------------
  // receive line synchroniser and edge detect
  // ---------------------------------------------------------------

  // three flops; the second and third stages feed edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_last_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_line;
      rx_sync_reg <= rx_meta_reg;
      rx_last_reg <= rx_sync_reg;
    end
  end

  // edges seen on the synchronised line
  assign rx_rise = rx_sync_reg & ~rx_last_reg;
  assign rx_fall = ~rx_sync_reg & rx_last_reg;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------

  // zero wait states: every access ends in its first access cycle
  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign rd_access = psel & penable & ~pwrite;
  assign addr_ok   = (paddr == OFS_BAUD_CONTROL) | (paddr == OFS_DIVISOR_LOW) |
                     (paddr == OFS_DIVISOR_HIGH) | (paddr == OFS_RECEIVE_DATA) |
                     (paddr == OFS_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_ok;
  assign wr_ctrl   = wr_access & (paddr == OFS_BAUD_CONTROL);
  // divisor belongs to the measurement while it runs
  assign wr_low    = wr_access & (paddr == OFS_DIVISOR_LOW) & ~measuring;
  assign wr_high   = wr_access & (paddr == OFS_DIVISOR_HIGH) & ~measuring;

  // read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata_reg <= 32'h0000_0000;
      case (paddr)
        OFS_BAUD_CONTROL: begin
          prdata_reg[BIT_ENABLE]    <= enable_reg;
          prdata_reg[BIT_WAKE]      <= wake_reg;
          prdata_reg[BIT_OVERFLOW]  <= overflow_reg;
          prdata_reg[BIT_WIDE]      <= wide_reg;
          prdata_reg[BIT_HIGH_SPD]  <= high_reg;
          prdata_reg[BIT_MEASURING] <= measuring;
        end
        OFS_DIVISOR_LOW:  prdata_reg[7:0] <= divisor_reg[7:0];
        OFS_DIVISOR_HIGH: prdata_reg[7:0] <= divisor_reg[15:8];
        OFS_RECEIVE_DATA: prdata_reg[7:0] <= rx_data;
        OFS_STATUS: begin
          prdata_reg[BIT_RX_FLAG] <= rx_flag_reg;
          prdata_reg[BIT_RX_IDLE] <= measuring;
        end
        default: prdata_reg <= 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  assign prdata = prdata_reg;

  // ---------------------------------------------------------------
  // control register bits
  // ---------------------------------------------------------------

  // enable: software sets, completion clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= 1'b0;
    end else if (done) begin
      enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      enable_reg <= pwdata[BIT_ENABLE];
    end
  end

  // wake on break: software sets, end of break clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_reg <= 1'b0;
    end else if (break_end) begin
      wake_reg <= 1'b0;
    end else if (wr_ctrl) begin
      wake_reg <= pwdata[BIT_WAKE];
    end
  end

  // overflow: set wins; a written zero clears only once enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_reg <= 1'b0;
    end else if (count_wrap) begin
      overflow_reg <= 1'b1;
    end else if (wr_ctrl & ~pwdata[BIT_OVERFLOW] & ~enable_reg) begin
      overflow_reg <= 1'b0;
    end
  end

  // rate select bits, plain software settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_reg <= 1'b0;
      high_reg <= 1'b0;
    end else if (wr_ctrl) begin
      wide_reg <= pwdata[BIT_WIDE];
      high_reg <= pwdata[BIT_HIGH_SPD];
    end
  end

  // receive flag: completion sets, data register read clears; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flag_reg <= 1'b0;
    end else if (done) begin
      rx_flag_reg <= 1'b1;
    end else if (rd_access & (paddr == OFS_RECEIVE_DATA)) begin
      rx_flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // measurement prescaler
  // ---------------------------------------------------------------

  // limit from the two rate bits: 512, 128 or 32 system clocks
  always_comb begin
    unique case ({wide_reg, high_reg})
      2'b00:   pre_last = PRE_LAST_SLOW;
      2'b11:   pre_last = PRE_LAST_FAST;
      default: pre_last = PRE_LAST_MID;
    endcase
  end

  // restarts at the first edge so the first period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 9'h000;
    end else if (first_edge | (state_reg != ST_COUNT) | tick) begin
      pre_reg <= 9'h000;
    end else begin
      pre_reg <= pre_reg + 9'h001;
    end
  end

  assign tick = (state_reg == ST_COUNT) & (pre_reg >= pre_last);

  // ---------------------------------------------------------------
  // measurement sequence
  // ---------------------------------------------------------------

  assign measuring  = (state_reg != ST_IDLE);
  assign break_end  = (state_reg == ST_BREAK_RISE) & enable_reg & rx_rise;
  assign first_edge = (state_reg == ST_FIRST_RISE) & enable_reg & rx_rise;
  assign done       = (state_reg == ST_COUNT) & enable_reg & rx_rise &
                      (edge_reg == EDGE_LAST - 3'h1);
  // no step on the stopping edge itself
  assign count_step = tick & enable_reg & ~done;
  assign count_wrap = count_step & (divisor_reg == CNT_MAX);

  // next state; clearing enable aborts from any state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (enable_reg) begin
          state_next = wake_reg ? ST_BREAK_FALL : ST_START_FALL;
        end
      end
      ST_BREAK_FALL: begin
        if (rx_fall) begin
          state_next = ST_BREAK_RISE;
        end
      end
      ST_BREAK_RISE: begin
        if (rx_rise) begin
          state_next = ST_START_FALL;
        end
      end
      ST_START_FALL: begin
        if (rx_fall) begin
          state_next = ST_FIRST_RISE;
        end
      end
      ST_FIRST_RISE: begin
        if (rx_rise) begin
          state_next = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!enable_reg) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // rising edges counted from the first one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_reg <= 3'h0;
    end else if (first_edge) begin
      edge_reg <= 3'h1;
    end else if ((state_reg == ST_COUNT) & rx_rise) begin
      edge_reg <= edge_reg + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // divisor pair: software bytes or the 16-bit measurement counter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_reg <= RST_DIVISOR;
    end else if (first_edge) begin
      divisor_reg <= CNT_START;
    end else if (count_step) begin
      divisor_reg <= divisor_reg + 16'h0001;
    end else if (wr_low) begin
      divisor_reg[7:0] <= pwdata[7:0];
    end else if (wr_high) begin
      divisor_reg[15:8] <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rx_hold_idle        = measuring;
  assign receive_int_flag    = rx_flag_reg;
  assign baud_divisor        = divisor_reg;
  assign wide_divisor_select = wide_reg;
  assign high_speed_select   = high_reg;

endmodule

/* File: sim/uabd_checker.sv */
/*
  port checker of the auto-baud measurement unit.
  assumes it is bound to uabd_top, one clock pclk, async reset presetn.
*/
`timescale 1ns/1ps
module uabd_checker
  import uabd_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial line and receiver
  input wire logic        rx_line,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_hold_idle,
  input wire logic        receive_int_flag,
  // divisor outputs
  input wire logic [15:0] baud_divisor,
  input wire logic        wide_divisor_select,
  input wire logic        high_speed_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic        ena_wr;    // access writing enable bit
  logic        rd_data;   // access reading receive data
  logic        chg;       // divisor differs from last cycle
  logic [15:0] div_q;     // divisor one cycle ago
  logic [9:0]  gap_reg;   // cycles since last divisor change
  logic [2:0]  seen_reg;  // divisor changes in this run
  logic [9:0]  gap_want;  // step spacing minus one
  assign ena_wr   = psel && penable && pwrite && paddr == OFS_BAUD_CONTROL && pwdata[BIT_ENABLE];
  assign rd_data  = psel && penable && !pwrite && paddr == OFS_RECEIVE_DATA;
  assign chg      = baud_divisor != div_q;
  assign gap_want = (wide_divisor_select && high_speed_select) ? 10'h01F :
                    ((wide_divisor_select || high_speed_select) ? 10'h07F : 10'h1FF);

  // spacing counter, restarted by every divisor change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q    <= 16'h0000;
      gap_reg  <= 10'h000;
      seen_reg <= 3'h0;
    end else begin
      div_q    <= baud_divisor;
      gap_reg  <= chg ? 10'h000 : gap_reg + 10'h001;
      if (!rx_hold_idle) begin
        seen_reg <= 3'h0;
      end else if (chg && seen_reg != 3'h7) begin
        seen_reg <= seen_reg + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_start;
    ena_wr && !rx_hold_idle |-> ##2 rx_hold_idle;
  endproperty
  a_start: assert property (p_start) else $error("enable write did not start measurement");
  property p_hold_cause;
    $rose(rx_hold_idle) |-> $past(ena_wr, 2);
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("receiver held idle without enable");
  property p_done;
    $rose(receive_int_flag) |-> $fell(rx_hold_idle);
  endproperty
  a_done: assert property (p_done) else $error("flag set apart from completion");
  property p_flag_clear;
    rd_data && !rx_hold_idle |=> !receive_int_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("data read left flag set");
  property p_flag_keep;
    receive_int_flag && !rd_data |=> receive_int_flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag dropped without data read");
  property p_div_hold;
    !rx_hold_idle && !(psel && penable && pwrite) |=> $stable(baud_divisor);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divisor moved outside measurement");
  property p_div_step;
    chg && rx_hold_idle |-> baud_divisor == div_q + 16'h0001 || baud_divisor == CNT_START;
  endproperty
  a_div_step: assert property (p_div_step) else $error("divisor step not one");
  property p_step_rate;
    chg && rx_hold_idle && seen_reg != 3'h0 |-> gap_reg == gap_want;
  endproperty
  a_step_rate: assert property (p_step_rate) else $error("divisor step spacing wrong");
  property p_sync;
    $rose(receive_int_flag) |-> $past(rx_line, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("completion too soon after line edge");

  // main scenarios
  c_done: cover property ($rose(receive_int_flag));
  c_abort: cover property ($fell(rx_hold_idle) && !receive_int_flag);
  c_step: cover property (chg && rx_hold_idle && seen_reg != 3'h0);
endmodule

bind uabd_top uabd_checker u_uabd_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .rx_line, .rx_data, .rx_hold_idle, .receive_int_flag, .baud_divisor,
  .wide_divisor_select, .high_speed_select);

/* File: sim/uabd_tx_model.sv */
/*
  remote serial transmitter: frames bytes lsb first, optional break first.
  assumes pclk is the unit's clock; line idles high between frames.
*/
`timescale 1ns/1ps
module uabd_tx_model (
  // clock
  input wire logic pclk,
  // serial line
  output logic     rx_line
);
  initial rx_line = 1'b1;

  // ---------------------------------------------------------------
  // frame sender: nb bits of start, data, stop, p cycles each
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] b, input int p, input bit brk, input int nb);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    if (brk) begin
      rx_line <= 1'b0;
      repeat (13 * p) @(posedge pclk);
      rx_line <= 1'b1;
      repeat (p) @(posedge pclk);
    end
    // first nb bits of the frame sent, start bit first, p cycles each
    for (int i = 0; i < nb; i++) begin
      rx_line <= fr[i];
      repeat (p) @(posedge pclk);
    end
    rx_line <= 1'b1;
  endtask
endmodule

/* File: sim/uart_autobaud_detect_bench.sv */
/*
  self-checking bench of the auto-baud unit over apb with a serial sender.
  assumes uabd_top, the checker bind and the sender model are compiled first.
*/
`timescale 1ns/1ps
module uart_autobaud_detect_bench;
  import uabd_pkg::*;
  // design ports
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [7:0]  rx_data = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        rx_hold_idle;
  logic        receive_int_flag;
  logic [15:0] baud_divisor;
  logic        wide_divisor_select;
  logic        high_speed_select;
  // bench state
  int          num_errors = 0;
  int          cmp_count  = 0;
  logic [31:0] rd;
  logic        er;
  int          wt;

  always #25 pclk = ~pclk;

  uabd_top u_uabd_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_line, .rx_data, .rx_hold_idle, .receive_int_flag, .baud_divisor,
    .wide_divisor_select, .high_speed_select);
  uabd_tx_model u_tx (.pclk, .rx_line);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // one apb transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wt = 0;
    do begin
      @(posedge pclk);
      wt++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rd_check(input logic [7:0] a, input logic [31:0] exp, input string n);
    apb(1'b0, a, 32'h0);
    check(n, rd, exp);
  endtask

  // measurement clock divide for the rate bits
  function automatic int rate(input logic w, input logic h);
    return (w && h) ? 32 : ((w || h) ? 128 : 512);
  endfunction

  // one full measurement of k steps in mode m
  task automatic measure(input logic [1:0] m, input bit brk, input int k);
    int          n;
    int          p;
    int          i;
    logic [15:0] e;
    logic [31:0] c;
    n = rate(m[0], m[1]);
    p = (n * k + n / 2) / 8;
    e = 16'(k + 1);
    c = 32'(m) << BIT_WIDE;
    rx_data <= 8'($urandom);
    apb(1'b1, OFS_DIVISOR_LOW, 32'($urandom % 256));
    apb(1'b1, OFS_BAUD_CONTROL, c | 32'h1 | (32'(brk) << BIT_WAKE));
    @(posedge pclk);
    check("hold", rx_hold_idle, 1'b1);
    check("wide", wide_divisor_select, m[0]);
    check("fast", high_speed_select, m[1]);
    u_tx.send(8'h55, p, brk, 10);
    i = 0;
    while (receive_int_flag !== 1'b1 && i < 20) begin
      @(posedge pclk);
      i++;
    end
    check("flag", receive_int_flag, 1'b1);
    check("divisor", baud_divisor, e);
    rd_check(OFS_DIVISOR_LOW, e[7:0], "low");
    rd_check(OFS_DIVISOR_HIGH, e[15:8], "high");
    rd_check(OFS_BAUD_CONTROL, c, "control");
    rd_check(OFS_STATUS, 32'h1, "status");
    rd_check(OFS_RECEIVE_DATA, rx_data, "data");
    check("flag clear", receive_int_flag, 1'b0);
    $display("test measure mode %0d wake %0d done", m, brk);
  endtask

  task conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(39));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, then one unmapped word
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check("reset value", rd, 32'h0);
      check("slave error", er, a == 20);
      check("access cycles", wt, 1);
    end
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      measure(2'(m), 1'b0, 2 + $urandom % (4096 / rate(m[0], m[1])));
    end
    measure(2'b11, 1'b1, 300);
    measure(2'b00, 1'b0, 2);
    // abort in mid character, then a character with no measurement
    apb(1'b1, OFS_BAUD_CONTROL, 32'h1);
    u_tx.send(8'h55, 40, 1'b0, 4);
    rd_check(OFS_BAUD_CONTROL, 32'h21, "measuring");
    apb(1'b1, OFS_DIVISOR_LOW, 32'hAB);
    apb(1'b1, OFS_BAUD_CONTROL, 32'h0);
    @(posedge pclk);
    check("abort hold", rx_hold_idle, 1'b0);
    u_tx.send(8'h55, 40, 1'b0, 10);
    check("abort flag", receive_int_flag, 1'b0);
    check("abort divisor", baud_divisor, 32'h1);
    $display("test abort done");
    conclude();
  end

  // watchdog against a hung wait
  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    conclude();
  end
endmodule
